// file: verilog/mwss_sequencer.sv
`timescale 1ns/1ps
module mwss_sequencer
#(
   parameter logic [8:0] SSRAM_RD_STALLS = 9'h001,
   parameter logic [8:0] EDO_STALLS      = 9'h005,
   parameter logic [8:0] ROM_S4_STALLS   = 9'h0AD,
   parameter logic [8:0] BW_B2B_STALLS   = 9'h001,
   parameter int         ROM_BYTE_CLKS   = 11
)
(
   input  wire logic                         ref_clk_i,
   input  wire logic                         srst_i,
   input  wire logic                         req_i,
   input  wire mwss_pkg::mwss_tgt_t          tgt_i,
   input  wire logic                         write_i,
   input  wire logic [mwss_pkg::BEATS_W-1:0] beats_i,
   input  wire logic                         aligned_i,
   input  wire logic                         full_i,
   input  wire logic                         bmask_valid_i,
   input  wire logic                         rdy_i,
   input  wire logic                         zws_n_i,
   input  wire logic [7:0]                   rom_byte_i,
   output logic                              ack_o,
   output logic                              wait_o,
   output logic                              done_o,
   output logic                              ras_o,
   output logic                              cas_o,
   output logic                              reload_o,
   output logic                              rfsh_o,
   output logic                              rom_rd_o,
   output logic [31:0]                       rom_word_o
);
   import mwss_pkg::*;

   // Byte timer is eight bits wide
   if (ROM_BYTE_CLKS < 2 || ROM_BYTE_CLKS > 255)
   begin : g_byte_clks_chk
      $error("ROM_BYTE_CLKS out of range");
   end

   typedef enum logic [1:0] {S_IDLE, S_HOLD, S_STALL, S_RECOV} mwss_state_t;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic        rdy_m_r, rdy_s_r, zws_m_r, zws_s_r;
   logic [7:0]  rb_m_r, rb_s_r;
   always_ff @(posedge ref_clk_i)
   begin
      rdy_m_r <= rdy_i;
      rdy_s_r <= rdy_m_r;
      zws_m_r <= zws_n_i;
      zws_s_r <= zws_m_r;
      rb_m_r  <= rom_byte_i;
      rb_s_r  <= rb_m_r;
   end

   // ****************************************
   // Stall lookup
   // ****************************************
   function automatic logic [8:0] stall_lookup(input mwss_tgt_t t, input logic wr,
                                               input logic [3:0] b, input logic al,
                                               input logic fu);
      logic [8:0] v;
      v = '0;
      case (t)
         T_SSRAM: v = wr ? 9'h000 : SSRAM_RD_STALLS;
         T_EDO:   v = EDO_STALLS;
         T_BEDO:
            if (b < 4'h2)
               v = wr ? BW_NSEQ : BR_NSEQ;
            else if (wr && fu && al && b == 4'h4)
               v = BW_FULL4;
            else if (wr && fu && al && b == 4'h8)
               v = BW_FULL8;
            else if (wr)
               v = (b == 4'h2) ? BW_S2 : (b == 4'h3) ? BW_S3 : (b == 4'h4) ? BW_S4 : BW_S8;
            else if (al)
               v = (b == 4'h2) ? BR_AL2 : (b == 4'h3) ? BR_AL3 : (b == 4'h4) ? BR_AL4 : BR_AL8;
            else
               v = (b == 4'h2) ? BR_UN2 : (b == 4'h3) ? BR_UN3 : (b == 4'h4) ? BR_UN4 : BR_UN8;
         T_ROM:
            if (wr)
               v = ROM_WR;
            else
               v = (b < 4'h2) ? ROM_NSEQ : (b == 4'h2) ? ROM_S2 : (b == 4'h3) ? ROM_S3 :
                   (b == 4'h4) ? ROM_S4_STALLS : ROM_S8;
         T_IO:    v = IO_NORM;
         default: v = '0;
      endcase
      return v;
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   mwss_state_t st_r, st_nxt;
   mwss_tgt_t   tgt_r;
   logic        wr_r, seq_r, al_r, full_r, rdrain;
   logic [3:0]  beats_r;
   logic [8:0]  cnt_r, tot_r;
   logic        rfsh_act_r, rfsh_pend_r;
   logic [3:0]  rfsh_cnt_r;
   logic [8:0]  rfsh_tmr_r;
   logic [1:0]  gap_r;
   logic        prev_pen_r, prev_bw_r;
   logic [7:0]  byte_tmr_r;
   logic [1:0]  byte_idx_r;
   logic [31:0] pack_r;

   wire         req_dram  = (tgt_i == T_EDO) || (tgt_i == T_BEDO);
   wire         take      = req_i && (st_r == S_IDLE);
   wire         near_b2b  = gap_r < B2B_GAP;
   wire  [8:0]  b2b_add   = !(req_dram && near_b2b) ? 9'h000 :
                            prev_pen_r ? PRECHG_EXTRA :
                            prev_bw_r  ? BW_B2B_STALLS : 9'h000;
   wire  [8:0]  base_tot  = stall_lookup(tgt_i, write_i, beats_i, aligned_i, full_i);
   wire  [8:0]  take_tot  = base_tot + b2b_add;
   wire         blocked   = take && req_dram && rfsh_act_r;
   wire         cur_dram  = (tgt_r == T_EDO) || (tgt_r == T_BEDO);
   wire         cur_bedo  = tgt_r == T_BEDO;
   wire         cur_io    = tgt_r == T_IO;
   wire         cur_rom   = (tgt_r == T_ROM) && !wr_r;
   wire         io_hold   = cur_io && !rdy_s_r;
   wire         mask_hold = cur_bedo && wr_r && seq_r && !full_r && !bmask_valid_i;
   wire         advance   = (st_r == S_STALL) && !io_hold && !mask_hold;
   wire         zws_end   = cur_io && !zws_s_r && (cnt_r >= IO_FAST - 9'h001);
   wire         finish    = advance && ((cnt_r == tot_r - 9'h001) || zws_end);
   wire         zero_done = take && !blocked && (take_tot == 9'h000);
   wire         enter     = (take && !blocked && take_tot != 9'h000) ||
                            (st_r == S_HOLD && !rfsh_act_r);
   wire         reload_pt = advance && cur_bedo && seq_r && !al_r &&
                            ((cnt_r == RELOAD_AT1) || (beats_r == 4'h8 && cnt_r == RELOAD_AT2));
   wire         dram_busy = (st_r != S_IDLE && cur_dram) || (take && req_dram);
   wire         rfsh_go   = rfsh_pend_r && !rfsh_act_r && !dram_busy;
   wire         byte_tick = advance && cur_rom && (byte_tmr_r == 8'(ROM_BYTE_CLKS - 1));

   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         S_IDLE:  if (blocked) st_nxt = S_HOLD;
                  else if (enter) st_nxt = S_STALL;
         S_HOLD:  if (!rfsh_act_r) st_nxt = S_STALL;
         S_STALL: if (finish) st_nxt = (cur_bedo && wr_r) ? S_RECOV : S_IDLE;
         S_RECOV: st_nxt = S_IDLE;
      endcase
   end

   // ****************************************
   // Access sequencer
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         st_r  <= S_IDLE;
         tgt_r <= T_SSRAM;
         {wr_r, seq_r, al_r, full_r} <= 4'h0;
         beats_r <= 4'h0;
         tot_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         if (take)
         begin
            tgt_r   <= tgt_i;
            wr_r    <= write_i;
            seq_r   <= beats_i > 4'h1;
            al_r    <= aligned_i;
            full_r  <= full_i;
            beats_r <= beats_i;
            tot_r   <= take_tot;
         end
         cnt_r <= enter ? 9'h000 : advance ? cnt_r + 9'h001 : cnt_r;
      end
   end

   // Outputs; RAS spans DRAM stall cycles (not refresh hold) plus the BEDO write recovery cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         {ack_o, wait_o, done_o, ras_o, cas_o, reload_o, rom_rd_o} <= 7'h00;
      end
      else
      begin
         ack_o    <= take;
         wait_o   <= (st_nxt == S_HOLD) || (st_nxt == S_STALL);
         done_o   <= finish || zero_done;
         ras_o    <= ((st_nxt == S_STALL) && (take ? req_dram : cur_dram)) ||
                     (st_nxt == S_RECOV);
         cas_o    <= enter && ((take ? tgt_i : tgt_r) == T_BEDO) &&
                     !(take ? write_i : wr_r);
         reload_o <= reload_pt;
         rom_rd_o <= byte_tick;
      end
   end

   // ****************************************
   // ROM byte packing
   // ****************************************
   // Same timer for EPROM and Flash; the faster part just idles
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         byte_tmr_r <= '0;
         byte_idx_r <= '0;
         pack_r     <= '0;
         rom_word_o <= '0;
      end
      else
      begin
         if (enter)
            byte_tmr_r <= '0;
         else if (advance)
            byte_tmr_r <= byte_tick ? 8'h00 : byte_tmr_r + 8'h01;
         if (enter)
            byte_idx_r <= '0;
         else if (byte_tick)
            byte_idx_r <= byte_idx_r + 2'h1;
         if (byte_tick)
            pack_r <= {rb_s_r, pack_r[31:8]};
         if (byte_tick && byte_idx_r == 2'h3)
            rom_word_o <= {rb_s_r, pack_r[31:8]};
      end
   end

   // ****************************************
   // Refresh and cycle overlap
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         rfsh_tmr_r  <= '0;
         rfsh_pend_r <= 1'b0;
         rfsh_act_r  <= 1'b0;
         rfsh_cnt_r  <= '0;
         rfsh_o      <= 1'b0;
         gap_r       <= 2'h3;
         prev_pen_r  <= 1'b0;
         prev_bw_r   <= 1'b0;
      end
      else
      begin
         rfsh_tmr_r  <= (rfsh_tmr_r == 9'(RFSH_INTERVAL - 1)) ? 9'h000 : rfsh_tmr_r + 9'h001;
         rfsh_pend_r <= (rfsh_tmr_r == 9'(RFSH_INTERVAL - 1)) || (rfsh_pend_r && !rfsh_go);
         if (rfsh_go)
            rfsh_cnt_r <= RFSH_LEN - 4'h1;
         else if (rfsh_act_r)
            rfsh_cnt_r <= rfsh_cnt_r - 4'h1;
         rfsh_act_r <= rfsh_go || (rfsh_act_r && rfsh_cnt_r != 4'h0);
         rfsh_o     <= rfsh_go || (rfsh_act_r && rfsh_cnt_r != 4'h0);
         // Only DRAM history matters; SSRAM and I/O leave no precharge
         if (finish || zero_done)
         begin
            gap_r      <= 2'h0;
            prev_pen_r <= zero_done ? (req_dram && !(tgt_i == T_BEDO && write_i)) :
                          ((tgt_r == T_EDO) || (cur_bedo && !wr_r));
            prev_bw_r  <= zero_done ? (tgt_i == T_BEDO && write_i) :
                          (cur_bedo && wr_r);
         end
         else if (st_r == S_IDLE && gap_r != 2'h3)
            gap_r <= gap_r + 2'h1;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [8:0] run_r, base_tot_q;
   logic       ext_r;
   always_ff @(posedge ref_clk_i)
   begin
      run_r <= (srst_i || done_o) ? 9'h000 : wait_o ? run_r + 9'h001 : run_r;
      ext_r <= (srst_i || done_o) ? 1'b0 : ext_r || (st_r == S_HOLD) || io_hold || mask_hold;
   end

   stall_exact_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_o && !ext_r && !(cur_io && !zws_s_r) |-> run_r == tot_r)
      else $error("wait length differs from stall count");
   prime_cas_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      cas_o |-> wait_o && cur_bedo && !wr_r ##1 !cas_o)
      else $error("priming CAS outside a BEDO read");
   wr_recov_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_o && cur_bedo && wr_r |-> ras_o ##1 !ras_o)
      else $error("BEDO write recovery cycle missing");
   no_abort_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      reload_o |-> !al_r && seq_r && cur_bedo)
      else $error("burst abort on aligned transfer");
   rfsh_len_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      $rose(rfsh_o) |-> rfsh_o [*8] ##1 rfsh_o ##1 !rfsh_o)
      else $error("refresh not nine clocks");
   rfsh_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      take && (tgt_i == T_SSRAM || tgt_i == T_IO) |=> st_r != S_HOLD)
      else $error("non-DRAM access held by refresh");
   io_min_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_o && cur_io |-> run_r >= IO_FAST)
      else $error("I/O cycle below minimum");
   b2b_pen_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      take && req_dram && near_b2b && prev_pen_r |=> tot_r == base_tot_q + 9'h001)
      else $error("precharge stall missing");
   always_ff @(posedge ref_clk_i)
      base_tot_q <= base_tot;

   bedo_rd_c: cover property (@(posedge ref_clk_i) take && tgt_i == T_BEDO && !write_i);
   io_zws_c:  cover property (@(posedge ref_clk_i) done_o && cur_io && run_r == IO_FAST);
   hold_c:    cover property (@(posedge ref_clk_i) st_r == S_HOLD ##1 st_r == S_STALL);
   rom8_c:    cover property (@(posedge ref_clk_i) done_o && cur_rom && tot_r == ROM_S8);
endmodule

// file: verilog/mwss_pkg.sv
package mwss_pkg;
   // ****************************************
   // Targets and widths
   // ****************************************
   typedef enum logic [2:0] {T_SSRAM, T_EDO, T_BEDO, T_ROM, T_IO} mwss_tgt_t;
   localparam int unsigned STALL_W       = 9;
   localparam int unsigned BEATS_W       = 4;
   // ****************************************
   // Stall figures
   // ****************************************
   localparam logic [8:0]  BR_NSEQ       = 9'h007;
   localparam logic [8:0]  BR_AL2        = 9'h008;
   localparam logic [8:0]  BR_AL3        = 9'h009;
   localparam logic [8:0]  BR_AL4        = 9'h00A;
   localparam logic [8:0]  BR_AL8        = 9'h013;
   localparam logic [8:0]  BR_UN2        = 9'h00C;
   localparam logic [8:0]  BR_UN3        = 9'h00D;
   localparam logic [8:0]  BR_UN4        = 9'h00E;
   localparam logic [8:0]  BR_UN8        = 9'h016;
   localparam logic [8:0]  BW_NSEQ       = 9'h004;
   localparam logic [8:0]  BW_S2         = 9'h006;
   localparam logic [8:0]  BW_S3         = 9'h008;
   localparam logic [8:0]  BW_S4         = 9'h00A;
   localparam logic [8:0]  BW_S8         = 9'h012;
   localparam logic [8:0]  BW_FULL4      = 9'h007;
   localparam logic [8:0]  BW_FULL8      = 9'h00C;
   localparam logic [8:0]  ROM_NSEQ      = 9'h02C;
   localparam logic [8:0]  ROM_S2        = 9'h057;
   localparam logic [8:0]  ROM_S3        = 9'h082;
   localparam logic [8:0]  ROM_S8        = 9'h159;
   localparam logic [8:0]  ROM_WR        = 9'h014;
   localparam logic [8:0]  IO_NORM       = 9'h014;
   localparam logic [8:0]  IO_FAST       = 9'h00D;
   // Column reload points inside an unaligned burst
   localparam logic [8:0]  RELOAD_AT1    = 9'h004;
   localparam logic [8:0]  RELOAD_AT2    = 9'h00C;
   // Back-to-back window, cycles since the last access ended
   localparam logic [1:0]  B2B_GAP       = 2'h2;
   localparam logic [8:0]  PRECHG_EXTRA  = 9'h001;
   // ****************************************
   // Refresh timing
   // ****************************************
   localparam longint      CLK_PERIOD_PS = 40000;
   localparam longint      RFSH_WIN_MS   = 32;
   localparam longint      RFSH_ROWS     = 2048;
   localparam int unsigned RFSH_INTERVAL =
      int'((RFSH_WIN_MS * 64'd1000000000) / (RFSH_ROWS * CLK_PERIOD_PS));
   localparam logic [3:0]  RFSH_LEN      = 4'h9;
endpackage

// file: verif/mwss_far_model.sv
`timescale 1ns/1ps
// ****************************************
// Far side: I/O card pins and ROM data bus
// ****************************************
module mwss_far_model
(
   input  wire logic       stretch_i,
   input  wire logic       fast_i,
   input  wire logic [7:0] byte_i,
   output logic            rdy_o,
   output logic            zws_n_o,
   output logic [7:0]      rom_byte_o
);
   // Pulled-up pins: ready unless the card stretches, no zero-wait unless asked
   assign rdy_o      = ~stretch_i;
   assign zws_n_o    = ~fast_i;
   // ROM holds one byte per access so packing can be judged without sync skew
   assign rom_byte_o = byte_i;
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   import mwss_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        req = 1'b0, wr = 1'b0, al = 1'b0, fu = 1'b0, bmv = 1'b1;
   logic        stretch = 1'b0, fast = 1'b0, rdy, zws_n;
   logic [3:0]  beats = 4'h0;
   logic [7:0]  byte_v = 8'h5A, rom_byte;
   mwss_tgt_t   tgt = T_SSRAM;
   logic        ack, wt, done, ras, cas, reload, rfsh, rom_rd;
   logic [31:0] rom_word;
   int          bad_count = 0, samples_checked = 0;
   int          n_stall, n_cas, n_rel, n_rd, n_ras;
   logic        ras_done;

   always #20 ref_clk_i = ~ref_clk_i;

   mwss_sequencer #(.SSRAM_RD_STALLS(9'h001), .EDO_STALLS(9'h005), .ROM_S4_STALLS(9'h0AD),
      .BW_B2B_STALLS(9'h001), .ROM_BYTE_CLKS(11)) mwss_sequencer_i (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req), .tgt_i(tgt), .write_i(wr),
      .beats_i(beats), .aligned_i(al), .full_i(fu), .bmask_valid_i(bmv), .rdy_i(rdy),
      .zws_n_i(zws_n), .rom_byte_i(rom_byte), .ack_o(ack), .wait_o(wt), .done_o(done),
      .ras_o(ras), .cas_o(cas), .reload_o(reload), .rfsh_o(rfsh), .rom_rd_o(rom_rd),
      .rom_word_o(rom_word));
   mwss_far_model mwss_far_model_i (.stretch_i(stretch), .fast_i(fast), .byte_i(byte_v),
      .rdy_o(rdy), .zws_n_o(zws_n), .rom_byte_o(rom_byte));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic timeout(input string what);
      bad_count++;
      $display("unexpected %s expected done seen hang", what);
      complete_run();
   endtask
   // One whole access: hold request until taken, then count until done
   task automatic access(input mwss_tgt_t t, input logic w, input logic [3:0] b,
      input logic a, input logic f);
      int k;
      n_stall = 0; n_cas = 0; n_rel = 0; n_rd = 0; n_ras = 0;
      tgt = t; wr = w; beats = b; al = a; fu = f; req = 1'b1;
      for (k = 0; k < 600 && ack !== 1'b1; k++) tick(1);
      if (k >= 600) timeout("ack");
      req = 1'b0;
      for (k = 0; k < 2000; k++)
      begin
         n_stall += int'(wt === 1'b1);
         n_cas += int'(cas === 1'b1);
         n_rel += int'(reload === 1'b1);
         n_rd += int'(rom_rd === 1'b1);
         n_ras += int'(ras === 1'b1);
         if (done === 1'b1) break;
         tick(1);
      end
      if (k >= 2000) timeout("done");
      ras_done = ras;
   endtask
   // Start DRAM work just after a refresh so none lands inside the batch
   task automatic sync_rfsh();
      int k;
      for (k = 0; k < 500 && rfsh !== 1'b1; k++) tick(1);
      for (k = 0; k < 20 && rfsh === 1'b1; k++) tick(1);
      if (k >= 20) timeout("refresh sync");
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_bedo_rd();
      logic [3:0] bt [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
      int ea [5] = '{7, 8, 9, 10, 19};
      int eu [5] = '{7, 12, 13, 14, 22};
      int er [5] = '{0, 1, 1, 1, 2};
      sync_rfsh();
      for (int i = 0; i < 10; i++)
      begin
         access(T_BEDO, 1'b0, bt[i/2], i % 2 == 0, 1'b0);
         check("bedo rd stalls", n_stall, (i % 2 == 0) ? ea[i/2] : eu[i/2]);
         check("bedo rd cas", n_cas, 1);
         check("bedo rd reload", n_rel, (i % 2 == 0) ? 0 : er[i/2]);
         tick(3);
      end
      $display("test_bedo_rd done");
   endtask
   task automatic test_bedo_wr();
      logic [3:0] bt [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
      int ew [5] = '{4, 6, 8, 10, 18};
      int ef [4] = '{7, 12, 10, 18};
      sync_rfsh();
      for (int i = 0; i < 14; i++)
      begin
         if (i < 10) access(T_BEDO, 1'b1, bt[i/2], i % 2 == 0, 1'b0);
         else access(T_BEDO, 1'b1, (i % 2 == 0) ? 4'h4 : 4'h8, i < 12, 1'b1);
         check("bedo wr stalls", n_stall, (i < 10) ? ew[i/2] : ef[i-10]);
         check("ras at done", ras_done, 1'b1);
         tick(1);
         check("ras after recovery", ras, 1'b0);
         tick(3);
      end
      $display("test_bedo_wr done");
   endtask
   task automatic test_mask();
      sync_rfsh();
      bmv = 1'b0;
      fork
         access(T_BEDO, 1'b1, 4'h2, 1'b1, 1'b0);
         begin
            tick(5);
            bmv = 1'b1;
         end
      join
      check("masked write stretched", n_stall > 6, 1'b1);
      tick(4);
      $display("test_mask done");
   endtask
   task automatic test_b2b();
      sync_rfsh();
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo after edo", n_stall, 6);
      access(T_SSRAM, 1'b0, 4'h1, 1'b0, 1'b0);
      check("ssram after dram", n_stall, 1);
      check("ssram row strobe", n_ras, 0);
      access(T_EDO, 1'b1, 4'h1, 1'b0, 1'b0);
      check("dram after ssram", n_stall, 5);
      access(T_IO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("io after dram", n_stall, 20);
      access(T_BEDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("dram after io", n_stall, 7);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo after bedo rd", n_stall, 6);
      access(T_BEDO, 1'b1, 4'h1, 1'b0, 1'b0);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo after bedo wr", n_stall, 5 + 1);
      access(T_SSRAM, 1'b1, 4'h1, 1'b0, 1'b0);
      check("ssram write", n_stall, 0);
      tick(1);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo after ssram write", n_stall, 5);
      tick(3);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo after gap", n_stall, 5);
      tick(3);
      $display("test_b2b done");
   endtask
   task automatic test_rom();
      logic [3:0] bt [4] = '{4'h1, 4'h2, 4'h3, 4'h8};
      int er [4] = '{44, 87, 130, 345};
      for (int i = 0; i < 4; i++)
      begin
         access(T_ROM, 1'b0, bt[i], 1'b0, 1'b0);
         check("rom rd stalls", n_stall, er[i]);
         check("rom bytes", n_rd, er[i] / 11);
         tick(3);
      end
      check("rom word", rom_word, {4{byte_v}});
      access(T_ROM, 1'b1, 4'h1, 1'b0, 1'b0);
      check("flash wr stalls", n_stall, 20);
      tick(3);
      $display("test_rom done");
   endtask
   task automatic test_io();
      for (int i = 0; i < 4; i++)
      begin
         fast = i > 1;
         tick(3);
         access(T_IO, i[0], 4'h1, 1'b0, 1'b0);
         check("io stalls", n_stall, (i > 1) ? 13 : 20);
      end
      fast = 1'b0;
      tick(3);
      fork
         access(T_IO, 1'b0, 4'h1, 1'b0, 1'b0);
         begin
            tick(3);
            stretch = 1'b1;
            tick(5);
            stretch = 1'b0;
         end
      join
      check("io stretched", n_stall, 25);
      tick(3);
      $display("test_io done");
   endtask
   task automatic test_rfsh();
      int k, len;
      sync_rfsh();
      for (k = 1; k < 500 && rfsh !== 1'b1; k++) tick(1);
      for (len = 0; len < 20 && rfsh === 1'b1; len++) tick(1);
      check("refresh length", len, 9);
      sync_rfsh();
      for (k = 0; k < 500 && rfsh !== 1'b1; k++) tick(1);
      check("refresh period", k + len, 32000000 / 2048 / 40);
      access(T_IO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("io during refresh", n_stall, 20);
      for (k = 0; k < 500 && rfsh !== 1'b1; k++) tick(1);
      access(T_SSRAM, 1'b0, 4'h1, 1'b0, 1'b0);
      check("ssram during refresh", n_stall, 1);
      access(T_EDO, 1'b0, 4'h1, 1'b0, 1'b0);
      check("edo held by refresh", n_stall > 5, 1'b1);
      $display("test_rfsh done");
   endtask

   initial
   begin
      tick(3);
      srst_i = 1'b0;
      test_bedo_rd();
      test_bedo_wr();
      test_mask();
      test_b2b();
      test_rom();
      test_io();
      test_rfsh();
      complete_run();
   end
endmodule
